/* core/acs_pkg.sv */
// package: constants and carriers for the conversion sequencer
package acs_pkg;
  localparam int RES_W           = 10;
  localparam int CONV_SLOW_CYC   = 62;
  localparam int CONV_FAST_CYC   = 31;
  localparam int STBY_WAIT_CYC   = 10;
  localparam logic       CLK_STOP_RST   = 1'b1;
  localparam logic [7:0] MODE_REG_RST   = 8'h30;
  localparam logic [7:0] START_REG_RST  = 8'h7F;
  localparam int MODE_SPEED_BIT  = 7;
  localparam int MODE_TRIG_BIT   = 6;
  localparam logic [3:0] CH_FIRST = 4'h4;
  localparam logic [3:0] CH_LAST  = 4'hB;

  typedef enum logic [2:0] {
    ACS_ACTIVE, ACS_SLEEP, ACS_WATCH, ACS_SUBACTIVE, ACS_SUBSLEEP, ACS_STANDBY
  } acs_pmode_t;

  typedef struct packed {
    logic       speed;
    logic       trig_en;
    logic [3:0] channel;
  } acs_mode_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } acs_result_t;
endpackage : acs_pkg

/* core/acs_result_mem.sv */
// result holding register pair, not touched by reset
`timescale 1ns/10ps
`default_nettype none
module acs_result_mem
  import acs_pkg::*;
#(
  parameter int W = RES_W
) (
  input  wire logic         core_clk,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output acs_result_t       rd_data
);
  acs_result_t mem_r;
  acs_result_t mem_nxt;

  always_comb begin
    mem_nxt = mem_r;
    if (wr_en) begin
      mem_nxt.high = wr_data[W-1:W-8];
      mem_nxt.low  = {wr_data[1:0], 6'h00};
    end
  end

  always_ff @(posedge core_clk) begin
    mem_r <= mem_nxt;
  end

  assign rd_data = mem_r;
endmodule : acs_result_mem
`default_nettype wire

/* core/acs_sequencer.sv */
// successive-approximation conversion sequencer
// Behaviour
// - successive approximation yields 10-bit result
// - start flag set, held, self-clears
// - completion sets done request flag
// - interrupt only while done enable set
// - trigger needs pin function and enable
// - selected trigger edge sets start flag
// - reset inits mode/start, keeps results
// - completion stores result, clears flag, idles
// - channel code 0101 selects input one
// - rewriting start flag 1 mid-conversion does not restart
// - clock stop bit 1 releases standby
// - channel field decode, 11xx prohibited
// - speed bit gives 62 or 31 cycles
// - writing 0 stops conversion
// - clock stop bit 0 halts converter
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire acs_pmode_t       power_mode,
  input  wire logic             mode_wr,
  input  wire acs_mode_t        mode_wdata,
  input  wire logic             start_wr,
  input  wire logic             start_wdata,
  input  wire logic             clk_stop_wr,
  input  wire logic             clk_stop_wdata,
  input  wire logic             trigger_pin_function_select,
  input  wire logic             trigger_edge_select,
  input  wire logic             ext_trigger_pin,
  input  wire logic             conv_done_irq_enable,
  input  wire logic             done_clr,
  input  wire logic             comparator_out,
  output logic [7:0]            conv_mode_reg,
  output logic [7:0]            conv_start_reg,
  output logic                  conv_start_flag,
  output logic                  conv_clock_stop_ctrl,
  output logic                  conv_done_request_flag,
  output logic                  conv_irq,
  output logic [7:0]            result_high_reg,
  output logic [7:0]            result_low_reg,
  output logic [RES_W-1:0]      sar_code,
  output logic                  sar_sample,
  output logic [7:0]            analog_select,
  output logic                  convert_busy
);
  typedef enum {ACS_IDLE, ACS_CONV} acs_state_t;

  // one-hot analog input enable; zero for no channel or prohibited code
  function automatic logic [7:0] ch_decode(input logic [3:0] ch);
    logic [7:0] sel;
    sel = 8'h00;
    if (ch >= CH_FIRST && ch <= CH_LAST) begin
      sel = 8'h01 << (ch - CH_FIRST);
    end
    return sel;
  endfunction : ch_decode

  //////////////////////////////////////////////////////////////////////////
  acs_state_t  state_r, state_nxt;
  acs_mode_t   mode_r, mode_nxt;
  logic        flag_r, flag_nxt;
  logic        stop_r, stop_nxt;
  logic        done_r, done_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [RES_W-1:0] sar_r, sar_nxt;
  logic        trg_s1_r, trg_s2_r, trg_s3_r;
  logic        trig_edge, run_ok, finish;
  logic [5:0]  conv_len;

  always_ff @(posedge core_clk) begin
    trg_s1_r <= ext_trigger_pin;
    trg_s2_r <= trg_s1_r;
    trg_s3_r <= trg_s2_r;
  end

  // edge select 1 = rising, 0 = falling
  assign trig_edge = trigger_pin_function_select & mode_r.trig_en &
                     (trigger_edge_select ? (trg_s2_r & ~trg_s3_r)
                                          : (~trg_s2_r & trg_s3_r));
  assign run_ok    = stop_r & (power_mode == ACS_ACTIVE || power_mode == ACS_SLEEP);
  assign conv_len  = mode_r.speed ? 6'(CONV_FAST_CYC) : 6'(CONV_SLOW_CYC);
  assign finish    = (state_r == ACS_CONV) && run_ok && flag_r && (cnt_r == conv_len - 6'd1);

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    flag_nxt  = flag_r;
    stop_nxt  = stop_r;
    done_nxt  = done_r;
    cnt_nxt   = cnt_r;
    bit_nxt   = bit_r;
    sar_nxt   = sar_r;
    if (mode_wr) begin
      mode_nxt = mode_wdata;
    end
    if (clk_stop_wr) begin
      stop_nxt = clk_stop_wdata;
    end
    if (done_clr) begin
      done_nxt = 1'b0;
    end
    if (finish) begin
      done_nxt = 1'b1;
    end
    case (state_r)
      ACS_IDLE: begin
        if (run_ok && ((start_wr && start_wdata) || trig_edge)) begin
          flag_nxt  = 1'b1;
          state_nxt = ACS_CONV;
          cnt_nxt   = '0;
          bit_nxt   = 4'(RES_W - 1);
          // first trial code: top bit raised, the rest clear
          sar_nxt   = {1'b1, {(RES_W-1){1'b0}}};
        end
      end
      ACS_CONV: begin
        if (start_wr && !start_wdata) begin
          flag_nxt  = 1'b0;
          state_nxt = ACS_IDLE;
        end else if (run_ok) begin
          cnt_nxt = cnt_r + 6'd1;
          // one decision per cycle after sampling, MSB first; next bit raised as trial
          if (cnt_r >= 6'd1 && cnt_r <= 6'(RES_W)) begin
            sar_nxt[bit_r] = comparator_out;
            if (bit_r != 4'd0) begin
              bit_nxt = bit_r - 4'd1;
              sar_nxt[bit_r - 4'd1] = 1'b1;
            end
          end
          if (finish) begin
            flag_nxt  = 1'b0;
            state_nxt = ACS_IDLE;
          end
        end
      end
      default: state_nxt = ACS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ACS_IDLE;
      mode_r  <= '0;
      flag_r  <= 1'b0;
      stop_r  <= CLK_STOP_RST;
      done_r  <= 1'b0;
      cnt_r   <= '0;
      bit_r   <= '0;
      sar_r   <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      flag_r  <= flag_nxt;
      stop_r  <= stop_nxt;
      done_r  <= done_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      sar_r   <= sar_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  acs_result_t res;
  logic [RES_W-1:0] res_data;
  assign res_data = sar_r;

  acs_result_mem #(.W(RES_W)) u_res (
    .core_clk (core_clk),
    .wr_en    (finish),
    .wr_data  (res_data),
    .rd_data  (res)
  );

  assign conv_mode_reg          = {mode_r.speed, mode_r.trig_en, MODE_REG_RST[5:4], mode_r.channel};
  assign conv_start_reg         = {flag_r, START_REG_RST[6:0]};
  assign conv_start_flag        = flag_r;
  assign conv_clock_stop_ctrl   = stop_r;
  assign conv_done_request_flag = done_r;
  assign conv_irq               = done_r & conv_done_irq_enable;
  assign result_high_reg        = res.high;
  assign result_low_reg         = res.low;
  assign sar_code               = sar_r;
  assign sar_sample             = (state_r == ACS_CONV) && (cnt_r == 6'd0);
  assign analog_select          = (state_r == ACS_CONV) ? ch_decode(mode_r.channel) : 8'h00;
  assign convert_busy           = (state_r == ACS_CONV);

  //////////////////////////////////////////////////////////////////////////
  a_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    conv_irq |-> (conv_done_request_flag && conv_done_irq_enable))
    else $error("irq without enabled done flag");
  a_done_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    finish |=> conv_done_request_flag && !conv_start_flag)
    else $error("completion did not set done flag");
  a_done_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
    (conv_done_request_flag && !done_clr) |=> conv_done_request_flag)
    else $error("done flag dropped without clear");
  a_stop_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (flag_r && start_wr && !start_wdata) |=> !conv_start_flag)
    else $error("stop write ignored");
  a_start_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_r == ACS_IDLE && run_ok && start_wr && start_wdata) |=> conv_start_flag)
    else $error("start write ignored");
  a_slow_len: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(flag_r) && !mode_r.speed && !mode_wr && !start_wr && !clk_stop_wr
     && power_mode == ACS_ACTIVE) |-> ##61 (finish || !run_ok || mode_r.speed || !flag_r))
    else $error("slow conversion length wrong");
  a_trig_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!convert_busy && !(start_wr && start_wdata)
     && !(trigger_pin_function_select && conv_mode_reg[MODE_TRIG_BIT]))
    |=> !conv_start_flag)
    else $error("trigger honoured while disabled");
  a_trig_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    (trig_edge && state_r == ACS_IDLE && run_ok) |=> conv_start_flag)
    else $error("trigger edge did not start");
  a_ch_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    (convert_busy && mode_r.channel == 4'h5) |-> analog_select == 8'h02)
    else $error("code 0101 not input one");
  a_standby_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!stop_r && state_r == ACS_CONV) |=> $stable(cnt_r))
    else $error("converter ran in standby");
  a_reset_vals: assert property (@(posedge core_clk)
    sys_rst |=> (conv_mode_reg == MODE_REG_RST && conv_start_reg == START_REG_RST
                 && conv_clock_stop_ctrl))
    else $error("reset values wrong");
endmodule : acs_sequencer
`default_nettype wire

/* testbench/acs_analog_model.sv */
// analog source model: one level per input and the comparator behind the ladder
`timescale 1ns/10ps
`default_nettype none
module acs_analog_model
  import acs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic [7:0]            analog_select,
  input  wire logic [RES_W-1:0]      sar_code,
  input  wire logic [7:0][RES_W-1:0] level,
  output logic                       comparator_out
);
  logic             wobble_r = 1'b0;
  logic [RES_W-1:0] vin;
  always_ff @(posedge core_clk) wobble_r <= ~wobble_r;
  always_comb begin
    vin = '0;
    for (int i = 0; i < 8; i++) if (analog_select[i]) vin = level[i];
  end
  // nothing routed: the comparator wanders rather than holding a level
  assign comparator_out = (analog_select != 8'h00) ? (vin >= sar_code) : wobble_r;
endmodule : acs_analog_model
`default_nettype wire

/* testbench/adc_conversion_sequencer_test.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_test;
  import acs_pkg::*;
  logic             core_clk = 1'b0, sys_rst = 1'b1;
  acs_pmode_t       power_mode = ACS_ACTIVE;
  acs_mode_t        mode_wdata = '0;
  logic             mode_wr = 0, start_wr = 0, start_wdata = 0, done_clr = 0;
  logic             clk_stop_wr = 0, clk_stop_wdata = 1, conv_done_irq_enable = 0;
  logic             trigger_pin_function_select = 0, trigger_edge_select = 0;
  logic             ext_trigger_pin = 1, comparator_out, conv_irq, sar_sample, convert_busy;
  logic [7:0]       conv_mode_reg, conv_start_reg, result_high_reg, result_low_reg;
  logic [7:0]       analog_select;
  logic             conv_start_flag, conv_clock_stop_ctrl, conv_done_request_flag;
  logic [RES_W-1:0] sar_code, last;
  logic [7:0][RES_W-1:0] level = '0;
  int               fail_count = 0, comparisons = 0, n;

  acs_sequencer dut (
    .core_clk, .sys_rst, .power_mode, .mode_wr, .mode_wdata, .start_wr, .start_wdata,
    .clk_stop_wr, .clk_stop_wdata, .trigger_pin_function_select, .trigger_edge_select,
    .ext_trigger_pin, .conv_done_irq_enable, .done_clr, .comparator_out, .conv_mode_reg,
    .conv_start_reg, .conv_start_flag, .conv_clock_stop_ctrl, .conv_done_request_flag,
    .conv_irq, .result_high_reg, .result_low_reg, .sar_code, .sar_sample, .analog_select,
    .convert_busy
  );
  acs_analog_model src (.core_clk, .analog_select, .sar_code, .level, .comparator_out);

  always #12.5 core_clk = ~core_clk;

  task automatic tick(input int k = 1);
    repeat (k) @(posedge core_clk);
    #2;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse
  task automatic wr_start(input logic v);
    start_wdata = v;
    pulse(start_wr);
  endtask : wr_start
  task automatic set_mode(input logic [3:0] ch, input logic spd, input logic trg);
    mode_wdata = '{speed: spd, trig_en: trg, channel: ch};
    pulse(mode_wr);
  endtask : set_mode
  task automatic run_to_end(output int k);
    k = 0;
    while (conv_start_flag === 1'b1 && k < 200) begin
      tick();
      k++;
    end
  endtask : run_to_end
  task automatic convert(input logic [3:0] ch, input logic spd, input logic [RES_W-1:0] v);
    level[3'(ch - 4'h4)] = v;
    last = v;
    set_mode(ch, spd, 1'b0);
    pulse(done_clr);
    wr_start(1'b1);
    check(conv_start_flag, 1'b1);
    check(convert_busy, 1'b1);
    check(sar_sample, 1'b1);
    check(analog_select, 8'h01 << (ch - 4'h4));
    run_to_end(n);
    check(n, spd ? 31 : 62);
    check(result_high_reg, v[9:2]);
    check(result_low_reg, {v[1:0], 6'h00});
    check(conv_done_request_flag, 1'b1);
    check(conv_irq, conv_done_irq_enable);
    check(conv_start_reg, 8'h7F);
    tick(3);
    check(conv_done_request_flag, 1'b1);
  endtask : convert
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    tick(20000);
    fail_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h90EC));
    tick(2);
    sys_rst = 1'b0;
    check(conv_mode_reg, 8'h30);
    check(conv_start_reg, 8'h7F);
    check(conv_clock_stop_ctrl, 1'b1);
    check(conv_irq, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      conv_done_irq_enable = i[0];
      convert(i < 2 ? 4'h5 : 4'(4 + $urandom_range(7)), 1'($urandom_range(1)),
              i == 0 ? 10'h3FF : i == 1 ? 10'h000 : 10'($urandom));
    end
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    check(conv_mode_reg, 8'h30);
    check(result_high_reg, last[9:2]);
    $display("test conversions done");
    set_mode(4'h6, 1'b0, 1'b0);
    pulse(done_clr);
    wr_start(1'b1);
    tick(5);
    wr_start(1'b0);
    check(conv_start_flag, 1'b0);
    tick(70);
    check(conv_done_request_flag, 1'b0);
    $display("test stop done");
    clk_stop_wdata = 1'b0;
    pulse(clk_stop_wr);
    check(conv_clock_stop_ctrl, 1'b0);
    wr_start(1'b1);
    tick(2);
    check(conv_start_flag, 1'b0);
    clk_stop_wdata = 1'b1;
    pulse(clk_stop_wr);
    tick(10);
    check(conv_clock_stop_ctrl, 1'b1);
    wr_start(1'b1);
    tick(3);
    power_mode = ACS_WATCH;
    tick(100);
    check(conv_start_flag, 1'b1);
    check(conv_done_request_flag, 1'b0);
    power_mode = ACS_SLEEP;
    tick(4);
    clk_stop_wdata = 1'b0;
    pulse(clk_stop_wr);
    tick(20);
    check(conv_start_flag, 1'b1);
    clk_stop_wdata = 1'b1;
    pulse(clk_stop_wr);
    run_to_end(n);
    check(n, 54);
    $display("test standby done");
    set_mode(4'h4, 1'b1, 1'b1);
    check(conv_mode_reg, 8'hF4);
    ext_trigger_pin = 1'b0;
    tick(6);
    check(conv_start_flag, 1'b0);
    trigger_pin_function_select = 1'b1;
    for (int e = 0; e < 2; e++) begin
      trigger_edge_select = e[0];
      ext_trigger_pin = ~e[0];
      tick(3);
      pulse(done_clr);
      ext_trigger_pin = e[0];
      tick(5);
      check(conv_start_flag, 1'b1);
      check(conv_done_request_flag, 1'b0);
      run_to_end(n);
      check(conv_done_request_flag, 1'b1);
    end
    $display("test trigger done");
    report_and_stop();
  end
endmodule : adc_conversion_sequencer_test
`default_nettype wire
